//--- core/spc_pkg.sv
// constants and types shared by the system pin control block
// assumes clk_i is the oscillator clock of the device
package spc_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_PERIOD_NS = 100;

  // reset input must stay low this many oscillator periods
  localparam int RST_IN_OSC = 64;
  // reset pin is pulled low at least this many periods on internal reset
  localparam int RST_OUT_OSC = 12;

  // least times, rounded up to whole clock cycles
  localparam int RST_IN_CYC =
    (RST_IN_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_OUT_CYC =
    (RST_OUT_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 8;

  // read or write strobe width of an external access, in cycles
  localparam int STB_CYC = 2;
  localparam int STB_W   = 2;

  // code fetch start address when external fetch is selected
  localparam logic [15:0] BOOT_VECTOR = 16'h0000;

  // port latches come out of reset as all ones, pins released
  localparam logic [7:0] PORT_RST_VAL = 8'hFF;

  typedef enum logic [2:0] {
    SPC_IDLE,
    SPC_ADDR,
    SPC_LATCH,
    SPC_STROBE,
    SPC_HOLD
  } spc_bus_st_t;

endpackage

//--- core/spc_slv_if.sv
// interface between the pin control top and its slave port engine
// assumes the host modport side samples pins on the common clock
`timescale 1ns/100ps
interface spc_slv_if;
  logic        en;
  logic        wide;
  logic        rd_n;
  logic        wr_n;
  logic [15:0] din;
  logic [15:0] rdata;
  logic        drive;
  logic [15:0] dout;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] wdata;

  modport host (output en, wide, rd_n, wr_n, din, rdata,
                input  drive, dout, wr_stb, rd_stb, wdata);
  modport slave (input  en, wide, rd_n, wr_n, din, rdata,
                 output drive, dout, wr_stb, rd_stb, wdata);
endinterface

//--- core/spc_reset_ctl.sv
// reset input filter, reset-out drive and boot strap latch
// assumes rst_pin_i is the reset pin level, already synchronous to clk_i
`timescale 1ns/100ps
module spc_reset_ctl (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic rst_pin_i,
  input  wire logic int_rst_req_i,
  input  wire logic low_power_i,
  input  wire logic ext_fetch_select_i,
  output logic      sys_rst_o,
  output logic      rst_drive_o,
  output logic      wake_o,
  output logic      ext_fetch_o
);

  logic [spc_pkg::CNT_W-1:0] low_cnt_reg, low_cnt_next;
  logic [spc_pkg::CNT_W-1:0] out_cnt_reg, out_cnt_next;
  logic ext_rst_reg, ext_rst_next;
  logic sys_rst_reg, sys_rst_next;
  logic drive_reg, drive_next;
  logic wake_reg, wake_next;
  logic fetch_reg, fetch_next;

  always_comb begin
    low_cnt_next = low_cnt_reg;
    ext_rst_next = ext_rst_reg;
    out_cnt_next = out_cnt_reg;
    fetch_next   = fetch_reg;
    wake_next    = 1'b0;
    // our own low drive reads back on the pin and must not count
    if (rst_pin_i || drive_reg) begin
      low_cnt_next = '0;
    end else if (low_cnt_reg < spc_pkg::CNT_W'(spc_pkg::RST_IN_CYC)) begin
      low_cnt_next = low_cnt_reg + 1'b1;
    end
    if (rst_pin_i) begin
      ext_rst_next = 1'b0;
    end else if (!drive_reg) begin
      if (low_cnt_reg == spc_pkg::CNT_W'(spc_pkg::RST_IN_CYC - 1)) begin
        ext_rst_next = 1'b1;
      end
      // oscillator may be stopped: no filter in idle or power-down
      if (low_power_i && !ext_rst_reg) begin
        ext_rst_next = 1'b1;
        wake_next    = 1'b1;
      end
    end
    if (int_rst_req_i) begin
      out_cnt_next = spc_pkg::CNT_W'(spc_pkg::RST_OUT_CYC);
    end else if (out_cnt_reg != '0) begin
      out_cnt_next = out_cnt_reg - 1'b1;
    end
    drive_next   = (out_cnt_next != '0);
    sys_rst_next = ext_rst_next || drive_next;
    if (sys_rst_reg) begin
      fetch_next = !ext_fetch_select_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      low_cnt_reg <= '0;
      out_cnt_reg <= '0;
      ext_rst_reg <= 1'b0;
      sys_rst_reg <= 1'b1;
      drive_reg   <= 1'b0;
      wake_reg    <= 1'b0;
      fetch_reg   <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      out_cnt_reg <= out_cnt_next;
      ext_rst_reg <= ext_rst_next;
      sys_rst_reg <= sys_rst_next;
      drive_reg   <= drive_next;
      wake_reg    <= wake_next;
      fetch_reg   <= fetch_next;
    end
  end

  assign sys_rst_o   = sys_rst_reg;
  assign rst_drive_o = drive_reg;
  assign wake_o      = wake_reg;
  assign ext_fetch_o = fetch_reg;

  // length of the current reset-out drive, for checking only
  logic [spc_pkg::CNT_W-1:0] drv_len_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      drv_len_reg <= '0;
    end else begin
      drv_len_reg <= drive_reg ? drv_len_reg + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_rst_out_len: assert property (
    $fell(rst_drive_o) |-> drv_len_reg >= spc_pkg::CNT_W'(spc_pkg::RST_OUT_CYC))
    else $error("reset pin released too early");
  chk_rst_filter: assert property (
    (!rst_pin_i && !rst_drive_o &&
     low_cnt_reg == spc_pkg::CNT_W'(spc_pkg::RST_IN_CYC - 1)) |=> sys_rst_o)
    else $error("long low reset input did not reset");
  chk_ea_hold: assert property (
    (!sys_rst_o && $past(sys_rst_o) == 1'b0) |-> $stable(ext_fetch_o))
    else $error("fetch select changed outside reset");
  chk_lp_wake: assert property (
    (low_power_i && !rst_pin_i && !rst_drive_o && !sys_rst_o) |=> sys_rst_o && wake_o)
    else $error("reset did not wake from low power");

endmodule

//--- core/spc_slave_port.sv
// slave port engine: the host strobes the read and write lanes
// assumes pins are synchronous to clk_i and the top registers drive values
`timescale 1ns/100ps
module spc_slave_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  spc_slv_if.slave s
);

  logic        rd_prev_reg, rd_prev_next;
  logic        wr_prev_reg, wr_prev_next;
  logic        wr_stb_reg, wr_stb_next;
  logic        rd_stb_reg, rd_stb_next;
  logic [15:0] wdata_reg, wdata_next;

  always_comb begin
    rd_prev_next = s.rd_n;
    wr_prev_next = s.wr_n;
    // data is taken when the host ends the write, once it is surely stable
    wr_stb_next  = s.en && s.wr_n && !wr_prev_reg;
    rd_stb_next  = s.en && !s.rd_n && rd_prev_reg;
    wdata_next   = wdata_reg;
    if (wr_stb_next) begin
      wdata_next = {s.wide ? s.din[15:8] : 8'h00, s.din[7:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
      wr_stb_reg  <= 1'b0;
      rd_stb_reg  <= 1'b0;
      wdata_reg   <= 16'h0000;
    end else begin
      rd_prev_reg <= rd_prev_next;
      wr_prev_reg <= wr_prev_next;
      wr_stb_reg  <= wr_stb_next;
      rd_stb_reg  <= rd_stb_next;
      wdata_reg   <= wdata_next;
    end
  end

  assign s.wr_stb = wr_stb_reg;
  assign s.rd_stb = rd_stb_reg;
  assign s.wdata  = wdata_reg;
  assign s.drive  = s.en && !s.rd_n;
  assign s.dout   = s.wide ? s.rdata : {8'h00, s.rdata[7:0]};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_slave_write: assert property (
    (s.en && s.wr_n && !wr_prev_reg) |=> s.wr_stb && s.wdata[7:0] == $past(s.din[7:0]))
    else $error("slave write not taken");
  chk_slave_narrow: assert property (
    (s.wr_stb && $past(s.wide) == 1'b0) |-> s.wdata[15:8] == 8'h00)
    else $error("high byte taken in narrow mode");

endmodule

//--- core/spc_top.sv
// system pin control: reset pins, external memory bus, slave port, boot strap
// assumes all pin inputs are synchronous to clk_i; pads resolve the enables
//
// Notes on behaviour
// - reset input held low 64 oscillator periods resets the device.
// - port pins go to reset state while the reset input is low.
// - reset input asserted in idle or power-down restores normal run.
// - internal reset pulls the reset pin low at least 12 periods.
// - low address sits on low lanes when the latch strobe falls.
// - latch strobe pulses only for external data moves, else stays low.
// - low lanes carry low address, then the data byte, per access.
// - high lanes carry the upper address bits during external accesses.
// - read strobe is asserted throughout each external data read.
// - write strobe is asserted throughout each external data write.
// - in slave mode the host drives read and write strobes as inputs.
// - slave data low byte on low lanes; high byte only in 16-bit mode.
// - fetch select held low starts code fetch externally at 0000h.
// - fetch select is caught during reset and held afterwards.
// - pull-up control output floats while the detach bit is set.
`timescale 1ns/100ps
module spc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_o,
  input  wire logic        int_rst_req_i,
  input  wire logic        low_power_i,
  output logic             sys_rst_o,
  output logic             wake_o,
  input  wire logic        external_fetch_select_i,
  output logic             code_fetch_ext_o,
  output logic [15:0]      boot_vector_o,
  input  wire logic        test_entry_pin_i,
  output logic             test_mode_o,
  input  wire logic        usb_detach_i,
  output logic             vref_o,
  output logic             vref_oe_o,
  input  wire logic        xreq_valid_i,
  input  wire logic        xreq_write_i,
  input  wire logic [15:0] xreq_addr_i,
  input  wire logic [7:0]  xreq_wdata_i,
  output logic             xreq_ready_o,
  output logic             xrsp_valid_o,
  output logic [7:0]       xrsp_rdata_o,
  input  wire logic        slave_mode_i,
  input  wire logic        slave_wide_i,
  input  wire logic [15:0] slv_rdata_i,
  output logic             slv_wr_o,
  output logic             slv_rd_o,
  output logic [15:0]      slv_wdata_o,
  input  wire logic [7:0]  ad_i,
  output logic [7:0]       ad_o,
  output logic             ad_oe_o,
  input  wire logic [7:0]  ahi_i,
  output logic [7:0]       ahi_o,
  output logic             ahi_oe_o,
  input  wire logic        rd_n_i,
  output logic             rd_n_o,
  output logic             rd_n_oe_o,
  input  wire logic        wr_n_i,
  output logic             wr_n_o,
  output logic             wr_n_oe_o,
  output logic             ale_o
);

  logic rst_drive;
  logic pin_rst;

  spc_reset_ctl u_rst (
    .clk_i              (clk_i),
    .rst_n_i            (rst_n_i),
    .rst_pin_i          (rst_pin_i),
    .int_rst_req_i      (int_rst_req_i),
    .low_power_i        (low_power_i),
    .ext_fetch_select_i (external_fetch_select_i),
    .sys_rst_o          (sys_rst_o),
    .rst_drive_o        (rst_drive),
    .wake_o             (wake_o),
    .ext_fetch_o        (code_fetch_ext_o)
  );

  // ports fall back while the pin is low even before the filter has run out
  assign pin_rst = !rst_pin_i || sys_rst_o;

  spc_slv_if slv ();

  assign slv.en    = slave_mode_i && !pin_rst;
  assign slv.wide  = slave_wide_i;
  assign slv.rd_n  = rd_n_i;
  assign slv.wr_n  = wr_n_i;
  assign slv.din   = {ahi_i, ad_i};
  assign slv.rdata = slv_rdata_i;

  spc_slave_port u_slv (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .s       (slv)
  );

  assign slv_wr_o    = slv.wr_stb;
  assign slv_rd_o    = slv.rd_stb;
  assign slv_wdata_o = slv.wdata;

  // external access sequencer state
  spc_pkg::spc_bus_st_t  st_reg, st_next;
  logic [spc_pkg::STB_W-1:0] cnt_reg, cnt_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0]  wdat_reg, wdat_next;
  logic        wr_reg, wr_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic        ready_reg, ready_next;

  always_comb begin
    st_next     = st_reg;
    cnt_next    = cnt_reg;
    addr_next   = addr_reg;
    wdat_next   = wdat_reg;
    wr_next     = wr_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    unique case (st_reg)
      spc_pkg::SPC_IDLE: begin
        if (xreq_valid_i && ready_reg && !slave_mode_i) begin
          st_next   = spc_pkg::SPC_ADDR;
          addr_next = xreq_addr_i;
          wdat_next = xreq_wdata_i;
          wr_next   = xreq_write_i;
        end
      end
      spc_pkg::SPC_ADDR: begin
        st_next = spc_pkg::SPC_LATCH;
      end
      spc_pkg::SPC_LATCH: begin
        st_next  = spc_pkg::SPC_STROBE;
        cnt_next = spc_pkg::STB_W'(spc_pkg::STB_CYC - 1);
      end
      spc_pkg::SPC_STROBE: begin
        if (cnt_reg == '0) begin
          st_next     = spc_pkg::SPC_HOLD;
          rvalid_next = 1'b1;
          if (!wr_reg) begin
            rdata_next = ad_i;
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      spc_pkg::SPC_HOLD: begin
        st_next = spc_pkg::SPC_IDLE;
      end
    endcase
    // an access cut short by reset gives no answer
    if (pin_rst) begin
      st_next     = spc_pkg::SPC_IDLE;
      rvalid_next = 1'b0;
    end
    ready_next = (st_next == spc_pkg::SPC_IDLE) && !slave_mode_i && !pin_rst;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg     <= spc_pkg::SPC_IDLE;
      cnt_reg    <= '0;
      addr_reg   <= 16'h0000;
      wdat_reg   <= 8'h00;
      wr_reg     <= 1'b0;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      ready_reg  <= 1'b0;
    end else begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      addr_reg   <= addr_next;
      wdat_reg   <= wdat_next;
      wr_reg     <= wr_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      ready_reg  <= ready_next;
    end
  end

  assign xreq_ready_o = ready_reg;
  assign xrsp_valid_o = rvalid_reg;
  assign xrsp_rdata_o = rdata_reg;

  // pin drive, computed from the next state so pins and state move together
  logic       ale_reg, ale_next;
  logic [7:0] ad_reg, ad_next;
  logic       ad_oe_reg, ad_oe_next;
  logic [7:0] ahi_reg, ahi_next;
  logic       ahi_oe_reg, ahi_oe_next;
  logic       rd_reg, rd_next;
  logic       wrs_reg, wrs_next;
  logic       strb_oe_reg, strb_oe_next;
  logic       mas_addr;
  logic       mas_data;

  always_comb begin
    mas_addr = (st_next == spc_pkg::SPC_ADDR) || (st_next == spc_pkg::SPC_LATCH);
    mas_data = wr_next &&
               ((st_next == spc_pkg::SPC_STROBE) || (st_next == spc_pkg::SPC_HOLD));
    ale_next     = (st_next == spc_pkg::SPC_ADDR);
    ad_oe_next   = mas_addr || mas_data;
    ad_next      = mas_addr ? addr_next[7:0] : wdat_next;
    ahi_oe_next  = (st_next != spc_pkg::SPC_IDLE);
    ahi_next     = addr_next[15:8];
    rd_next      = !((st_next == spc_pkg::SPC_STROBE) && !wr_next);
    wrs_next     = !((st_next == spc_pkg::SPC_STROBE) && wr_next);
    strb_oe_next = 1'b1;
    // the slave port owns the lanes only while no master access runs
    if (slv.en && st_next == spc_pkg::SPC_IDLE) begin
      ad_oe_next   = slv.drive;
      ad_next      = slv.dout[7:0];
      ahi_oe_next  = slv.drive && slave_wide_i;
      ahi_next     = slv.dout[15:8];
      strb_oe_next = 1'b0;
      rd_next      = 1'b1;
      wrs_next     = 1'b1;
    end
    if (pin_rst) begin
      ale_next     = 1'b0;
      ad_oe_next   = 1'b0;
      ad_next      = spc_pkg::PORT_RST_VAL;
      ahi_oe_next  = 1'b0;
      ahi_next     = spc_pkg::PORT_RST_VAL;
      rd_next      = 1'b1;
      wrs_next     = 1'b1;
      strb_oe_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ale_reg     <= 1'b0;
      ad_reg      <= spc_pkg::PORT_RST_VAL;
      ad_oe_reg   <= 1'b0;
      ahi_reg     <= spc_pkg::PORT_RST_VAL;
      ahi_oe_reg  <= 1'b0;
      rd_reg      <= 1'b1;
      wrs_reg     <= 1'b1;
      strb_oe_reg <= 1'b0;
    end else begin
      ale_reg     <= ale_next;
      ad_reg      <= ad_next;
      ad_oe_reg   <= ad_oe_next;
      ahi_reg     <= ahi_next;
      ahi_oe_reg  <= ahi_oe_next;
      rd_reg      <= rd_next;
      wrs_reg     <= wrs_next;
      strb_oe_reg <= strb_oe_next;
    end
  end

  assign ale_o     = ale_reg;
  assign ad_o      = ad_reg;
  assign ad_oe_o   = ad_oe_reg;
  assign ahi_o     = ahi_reg;
  assign ahi_oe_o  = ahi_oe_reg;
  assign rd_n_o    = rd_reg;
  assign wr_n_o    = wrs_reg;
  assign rd_n_oe_o = strb_oe_reg;
  assign wr_n_oe_o = strb_oe_reg;

  // misc pins: reset-out drive, strap results, test entry, usb pull-up
  logic        rst_oe_reg;
  logic [15:0] boot_reg;
  logic        test_reg;
  logic        vref_oe_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_oe_reg  <= 1'b0;
      boot_reg    <= spc_pkg::BOOT_VECTOR;
      test_reg    <= 1'b0;
      vref_oe_reg <= 1'b0;
    end else begin
      rst_oe_reg  <= rst_drive;
      boot_reg    <= spc_pkg::BOOT_VECTOR;
      // a low test entry pin means test mode; normal use keeps it high
      test_reg    <= !test_entry_pin_i;
      vref_oe_reg <= !usb_detach_i;
    end
  end

  // open drain: only ever pulls low, the enable does the work
  assign rst_pin_o     = 1'b0;
  assign rst_pin_oe_o  = rst_oe_reg;
  assign boot_vector_o = boot_reg;
  assign test_mode_o   = test_reg;
  assign vref_o        = 1'b1;
  assign vref_oe_o     = vref_oe_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || pin_rst);

  sequence s_rd_strobe;
    (!rd_n_o && !ad_oe_o) [*2] ##1 rd_n_o;
  endsequence

  sequence s_wr_strobe;
    (!wr_n_o && ad_oe_o && ad_o == wdat_reg) [*2] ##1 (wr_n_o && ad_o == wdat_reg);
  endsequence

  chk_ale_xfer: assert property (
    ale_o |-> st_reg == spc_pkg::SPC_ADDR)
    else $error("latch strobe outside an access");
  chk_ale_fall_addr: assert property (
    ale_o |=> !ale_o && ad_oe_o && $stable(ad_o) && ad_o == addr_reg[7:0])
    else $error("address not held at latch strobe fall");
  chk_rd_strobe: assert property (
    (st_reg == spc_pkg::SPC_LATCH && !wr_reg) |=> s_rd_strobe)
    else $error("read strobe wrong");
  chk_wr_strobe: assert property (
    (st_reg == spc_pkg::SPC_LATCH && wr_reg) |=> s_wr_strobe)
    else $error("write strobe or data wrong");
  chk_mux_lanes: assert property (
    (ale_o && wr_reg) |-> ad_o == addr_reg[7:0] ##3 ad_o == wdat_reg)
    else $error("low lanes not multiplexed");
  chk_ahi_drive: assert property (
    (st_reg != spc_pkg::SPC_IDLE) |-> ahi_oe_o && ahi_o == addr_reg[15:8])
    else $error("high address lanes not driven");
  chk_slave_narrow_hi: assert property (
    (slave_mode_i && !slave_wide_i && st_reg == spc_pkg::SPC_IDLE &&
     st_next == spc_pkg::SPC_IDLE) |=> !ahi_oe_o)
    else $error("high lanes driven in narrow slave mode");
  chk_pin_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rst_pin_i |=> !ad_oe_o && !ale_o && rd_n_o && !rd_n_oe_o && !ahi_oe_o)
    else $error("ports not in reset state");
  chk_vref_detach: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    usb_detach_i |=> !vref_oe_o)
    else $error("pull-up driven while detached");
  chk_boot_vec: assert property (
    code_fetch_ext_o |-> boot_vector_o == spc_pkg::BOOT_VECTOR)
    else $error("external fetch not at start address");

endmodule

//--- verification/spc_mem_model.sv
// external byte memory with address latch, far side of the master bus
// assumes strobes and lanes are registered by the device on clk_i
`timescale 1ns/100ps
module spc_mem_model (
  input  wire logic        clk_i,
  input  wire logic        ale_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [7:0]  ad_i,
  input  wire logic [7:0]  ahi_i,
  output logic [7:0]       ad_o,
  output logic [15:0]      addr_o
);
  logic [7:0] mem [0:255];
  logic       ale_d;
  logic       wr_d;
  logic [7:0] last;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    ale_d = 1'b0;
    wr_d = 1'b1;
    last = 8'h00;
    addr_o = 16'h0000;
  end

  // lanes float when not read, so show the inverse of the last value
  assign ad_o = !rd_n_i ? mem[addr_o[7:0]] : ~last;

  always @(posedge clk_i) begin
    ale_d <= ale_i;
    wr_d <= wr_n_i;
    last <= ad_o;
    if (ale_d && !ale_i) begin
      addr_o <= {ahi_i, ad_i};
    end
    if (!wr_d && wr_n_i) begin
      mem[addr_o[7:0]] <= ad_i;
    end
  end
endmodule

//--- verification/tb_system_pin_control.sv
// self-checking bench for the system pin control top
// assumes the memory model answers master accesses on the low lanes
`timescale 1ns/100ps
module tb_system_pin_control;
  logic        clk_i = 0, rst_n_i = 0, pin = 1, int_rst_req_i = 0, low_power_i = 0;
  logic        external_fetch_select_i = 0, test_entry_pin_i = 1, usb_detach_i = 0;
  logic        xreq_valid_i = 0, xreq_write_i = 0, slave_mode_i = 0, slave_wide_i = 0;
  logic [15:0] xreq_addr_i = 16'h0000, slv_rdata_i = 16'h0000, boot_vector_o, slv_wdata_o;
  logic [15:0] mem_addr;
  logic [7:0]  xreq_wdata_i = 8'h00, tb_ad = 8'h00, ahi_i = 8'h00, mem_ad, q;
  logic        rd_n_i = 1, wr_n_i = 1, rst_pin_i, rst_pin_o, rst_pin_oe_o, sys_rst_o, wake_o;
  logic        code_fetch_ext_o, test_mode_o, vref_o, vref_oe_o, xreq_ready_o, xrsp_valid_o;
  logic        slv_wr_o, slv_rd_o, ad_oe_o, ahi_oe_o, rd_n_o, rd_n_oe_o, wr_n_o, wr_n_oe_o;
  logic        ale_o;
  logic [7:0]  xrsp_rdata_o, ad_i, ad_o, ahi_o;
  int          fail_count = 0, n_checks = 0;

  always #50 clk_i = ~clk_i;
  // open-drain reset pin: the device pulls it low over the outside level
  assign rst_pin_i = pin & ~rst_pin_oe_o;
  assign ad_i = slave_mode_i ? tb_ad : mem_ad;

  spc_top dut (.clk_i, .rst_n_i, .rst_pin_i, .rst_pin_o, .rst_pin_oe_o, .int_rst_req_i,
    .low_power_i, .sys_rst_o, .wake_o, .external_fetch_select_i, .code_fetch_ext_o,
    .boot_vector_o, .test_entry_pin_i, .test_mode_o, .usb_detach_i, .vref_o, .vref_oe_o,
    .xreq_valid_i, .xreq_write_i, .xreq_addr_i, .xreq_wdata_i, .xreq_ready_o,
    .xrsp_valid_o, .xrsp_rdata_o, .slave_mode_i, .slave_wide_i, .slv_rdata_i, .slv_wr_o,
    .slv_rd_o, .slv_wdata_o, .ad_i, .ad_o, .ad_oe_o, .ahi_i, .ahi_o, .ahi_oe_o, .rd_n_i,
    .rd_n_o, .rd_n_oe_o, .wr_n_i, .wr_n_o, .wr_n_oe_o, .ale_o);

  spc_mem_model mem (.clk_i, .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .ad_i(ad_o), .ahi_i(ahi_o), .ad_o(mem_ad), .addr_o(mem_addr));

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic t_boot;
    chk({sys_rst_o, ale_o, code_fetch_ext_o}, 17'h1);
    chk(boot_vector_o, 16'h0000);
    external_fetch_select_i = 1;
    cyc(3);
    chk(code_fetch_ext_o, 1'b1);
    $display("boot strap test done");
  endtask

  // one external data move; checks lanes, latch strobe and strobe width
  task automatic xacc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n, ales, stb;
    ales = 0;
    stb = 0;
    xreq_valid_i = 1;
    xreq_write_i = w;
    xreq_addr_i = a;
    xreq_wdata_i = d;
    for (n = 0; n < 20 && xreq_ready_o !== 1'b1; n++) cyc(1);
    cyc(1);
    xreq_valid_i = 0;
    for (n = 0; n < 6; n++) begin
      if (ale_o === 1'b1) begin
        ales++;
        chk({ad_oe_o, ahi_o, ad_o}, {1'b1, a});
      end
      if ((w ? wr_n_o : rd_n_o) === 1'b0) begin
        stb++;
        chk({ahi_oe_o, ahi_o}, {1'b1, a[15:8]});
        if (w) chk({ad_oe_o, ad_o}, {1'b1, d});
      end
      if (xrsp_valid_o === 1'b1) q = xrsp_rdata_o;
      cyc(1);
    end
    chk(17'(ales), 17'd1);
    chk(17'(stb), 17'(spc_pkg::STB_CYC));
    chk(mem_addr, a);
  endtask

  task automatic t_master;
    q = 8'h00;
    xacc(0, 16'hA35C, 8'h00);
    chk(q, 8'h5C ^ 8'h5A);
    xacc(1, 16'h7E81, 8'hC6);
    xacc(0, 16'h7E81, 8'h00);
    chk(q, 8'hC6);
    $display("master bus test done");
  endtask

  task automatic t_slave(input logic wide);
    int n;
    logic seen;
    slave_mode_i = 1;
    slave_wide_i = wide;
    tb_ad = 8'h3C;
    ahi_i = 8'hC3;
    wr_n_i = 0;
    cyc(1);
    wr_n_i = 1;
    seen = 0;
    for (n = 0; n < 4; n++) begin
      cyc(1);
      seen |= slv_wr_o;
    end
    chk({seen, slv_wdata_o}, {1'b1, wide ? 16'hC33C : 16'h003C});
    chk({rd_n_oe_o, wr_n_oe_o, ale_o}, 17'h0);
    slv_rdata_i = 16'h9A65;
    rd_n_i = 0;
    seen = 0;
    for (n = 0; n < 4 && ad_oe_o !== 1'b1; n++) begin
      cyc(1);
      seen |= slv_rd_o;
    end
    chk({seen, ad_oe_o, ad_o}, 17'h165 | 17'h200);
    chk(ahi_oe_o, wide);
    if (wide) chk(ahi_o, 8'h9A);
    rd_n_i = 1;
    cyc(3);
    slave_mode_i = 0;
    cyc(2);
    $display("slave port test done");
  endtask

  task automatic t_pins;
    test_entry_pin_i = 0;
    usb_detach_i = 1;
    cyc(2);
    chk({test_mode_o, vref_oe_o}, 17'h2);
    test_entry_pin_i = 1;
    usb_detach_i = 0;
    cyc(2);
    chk({test_mode_o, vref_oe_o, vref_o}, 17'h3);
    $display("pin control test done");
  endtask

  task automatic t_reset;
    int n;
    pin = 0;
    // the 64th low sample resets, so one cycle earlier the core still runs
    cyc(63);
    chk({sys_rst_o, ad_oe_o, ahi_o}, 17'hFF);
    cyc(1);
    chk(sys_rst_o, 1'b1);
    pin = 1;
    cyc(3);
    chk({sys_rst_o, xreq_ready_o}, 17'h1);
    int_rst_req_i = 1;
    cyc(1);
    int_rst_req_i = 0;
    // the pin enable trails the internal drive by one register stage
    cyc(1);
    chk({rst_pin_oe_o, rst_pin_o}, 17'h2);
    for (n = 0; n < 40 && rst_pin_oe_o === 1'b1; n++) cyc(1);
    chk(17'(n >= spc_pkg::RST_OUT_CYC), 17'h1);
    cyc(4);
    low_power_i = 1;
    pin = 0;
    cyc(1);
    chk({sys_rst_o, wake_o}, 17'h3);
    pin = 1;
    low_power_i = 0;
    cyc(4);
    chk(sys_rst_o, 1'b0);
    $display("reset pin test done");
  endtask

  initial begin
    #(100ns * 20000);
    fail_count++;
    finish_test();
  end

  initial begin
    cyc(16);
    rst_n_i = 1;
    cyc(3);
    t_boot();
    t_master();
    t_slave(1);
    t_slave(0);
    t_pins();
    t_reset();
    t_master();
    finish_test();
  end
endmodule
